// ===== bench/bpm_cell_model.sv
// Behavioural cell, pack terminal, charger and load seen through the comparators
`timescale 1ns/1ns
module bpm_cell_model (
  input wire logic cell_hi,
  input wire logic cell_lo,
  input wire logic chg_oc,
  input wire logic dis_oc,
  input wire logic short_c,
  input wire logic charger,
  input wire logic test_pulldown_en,
  input wire logic test_pullup_en,
  output logic cmp_vin_gt_ov,
  output logic cmp_vin_lt_uv,
  output logic cmp_vin_lt_ce,
  output logic cmp_is_gt_oc,
  output logic cmp_is_lt_neg_oc,
  output logic cmp_is_le_neg_2mv,
  output logic cmp_sns_gt_sc,
  output logic cmp_pls_gt_vin,
  output logic cmp_pls_gt_vdd,
  output logic cmp_vdd_gt_2v2,
  output logic cmp_pls_lt_vdd_tp,
  output logic cmp_pls_gt_vdd_tp
);
  assign cmp_vin_gt_ov = cell_hi;
  assign cmp_vin_lt_uv = cell_lo;
  // A cell not over the limit sits below the charge enable level
  assign cmp_vin_lt_ce = !cell_hi;
  assign cmp_is_gt_oc = chg_oc;
  assign cmp_is_lt_neg_oc = dis_oc;
  assign cmp_is_le_neg_2mv = dis_oc;
  assign cmp_sns_gt_sc = short_c;
  assign cmp_pls_gt_vin = charger;
  assign cmp_pls_gt_vdd = charger;
  // Supply never drops to the recovery floor here, so recovery charging is not modelled
  assign cmp_vdd_gt_2v2 = 1'b1;
  // The offending source or load holds pack-plus against the test current until removed
  assign cmp_pls_lt_vdd_tp = test_pulldown_en && !charger;
  assign cmp_pls_gt_vdd_tp = test_pullup_en && !dis_oc && !short_c;
endmodule

// ===== bench/bpm_mode_ctrl_props.sv
// Port checker for the protection mode controller, bound to its top module
`timescale 1ns/1ns
module bpm_mode_ctrl_props #(
  parameter int OVD_CYC = 20,
  parameter int UVD_CYC = 20,
  parameter int OCD_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_switch_input_n,
  input wire logic cmp_vin_gt_ov,
  input wire logic cmp_vin_lt_uv,
  input wire logic cmp_is_gt_oc,
  input wire logic cmp_is_lt_neg_oc,
  input wire logic charge_fet_control,
  input wire logic discharge_fet_control,
  input wire logic active_mode,
  input wire logic test_pulldown_en,
  input wire logic test_pullup_en
);
  // ======
  // Run lengths
  // Margin of 6 covers two sync stages, the qualify edge and the output register
  logic [7:0] ov_run_ff;
  logic [7:0] uv_run_ff;
  logic [7:0] coc_run_ff;
  logic [7:0] doc_run_ff;

  function automatic logic [7:0] nxt_run(input logic [7:0] c, input logic cond);
    return cond ? c + 8'(c != 8'hFF) : 8'h00;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_run_ff <= 8'h00;
      uv_run_ff <= 8'h00;
      coc_run_ff <= 8'h00;
      doc_run_ff <= 8'h00;
    end else begin
      ov_run_ff <= nxt_run(ov_run_ff, cmp_vin_gt_ov && active_mode);
      uv_run_ff <= nxt_run(uv_run_ff, cmp_vin_lt_uv && active_mode);
      coc_run_ff <= nxt_run(coc_run_ff, cmp_is_gt_oc && active_mode);
      doc_run_ff <= nxt_run(doc_run_ff, cmp_is_lt_neg_oc && active_mode);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RST_SLEEP: assert property ($rose(presetn) |-> !active_mode)
    else $error("Not asleep after reset");
  AST_SLEEP_FETS_OFF: assert property (
    !active_mode && !$past(active_mode) |-> charge_fet_control && discharge_fet_control)
    else $error("FET control on in sleep");
  AST_SWITCH_WAKE: assert property (
    (!power_switch_input_n) [*4] |-> ##[0:2] active_mode)
    else $error("Switch did not wake");
  AST_OV_CHARGE_OFF: assert property (
    ov_run_ff >= OVD_CYC + 6 |-> charge_fet_control && !discharge_fet_control)
    else $error("Overvoltage response wrong");
  AST_UV_SLEEPS: assert property (uv_run_ff <= UVD_CYC + 6)
    else $error("Undervoltage did not sleep");
  AST_COC_BOTH_OFF: assert property (
    coc_run_ff >= OCD_CYC + 6 |-> charge_fet_control && discharge_fet_control && test_pulldown_en)
    else $error("Charge overcurrent response wrong");
  AST_DOC_OFF: assert property (
    doc_run_ff >= OCD_CYC + 6 |-> discharge_fet_control && test_pullup_en)
    else $error("Discharge overcurrent response wrong");
  AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("No ready after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("Refused read returned data");

  cover property ($rose(active_mode));
  cover property ($rose(test_pullup_en));
  cover property (pready && pslverr);
endmodule

bind bpm_mode_ctrl bpm_mode_ctrl_props #(.OVD_CYC(OVD_CYC), .UVD_CYC(UVD_CYC), .OCD_CYC(OCD_CYC))
  u_props (.*);

// ===== bench/bpm_mode_ctrl_tb_top.sv
// Self-checking bench for the protection mode controller
`timescale 1ns/1ns
module bpm_mode_ctrl_tb_top
  import bpm_pkg::*;
;
  localparam int DQ = 40;
  localparam int DLY = 20;
  localparam int SCD = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_valid, rd_err;
  logic [11:0] paddr, adc_sample, smp;
  logic [31:0] pwdata, prdata, rd_data;
  logic host_data_line, power_switch_input_n, active_mode;
  logic charge_fet_control, discharge_fet_control, test_pulldown_en, test_pullup_en;
  logic cell_hi, cell_lo, chg_oc, dis_oc, short_c, charger;
  logic cmp_vin_gt_ov, cmp_vin_lt_uv, cmp_vin_lt_ce, cmp_is_gt_oc, cmp_is_lt_neg_oc;
  logic cmp_is_le_neg_2mv, cmp_sns_gt_sc, cmp_pls_gt_vin, cmp_pls_gt_vdd, cmp_vdd_gt_2v2;
  logic cmp_pls_lt_vdd_tp, cmp_pls_gt_vdd_tp;
  logic [15:0] rnd;
  logic [7:0] bias;
  int err_total = 0;
  int num_checks = 0;

  bpm_mode_ctrl #(.DQ_LOW_CYC(DQ), .OVD_CYC(DLY), .UVD_CYC(DLY), .OCD_CYC(DLY),
    .SCD_CYC(SCD)) uut (.*);
  bpm_cell_model model (.*);

  // ======
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] exp_cur(input logic [11:0] s, input logic [7:0] b);
    int v;
    v = int'($signed(s)) - int'($signed(b));
    if (v > 2047) v = 2047;
    if (v < -2048) v = -2048;
    return {20'h0, 12'(v)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps a following setup from assigning psel in the same step
    tick(1);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd_data, exp);
  endtask

  task automatic wait_mode(input logic m);
    int n;
    n = 0;
    while (active_mode !== m && n < 300) begin
      tick(1);
      n++;
    end
    chk(active_mode, m);
  endtask

  task automatic feed(input logic [11:0] s, input int n);
    repeat (n) begin
      adc_sample <= s;
      adc_valid <= 1'b1;
      tick(1);
      adc_valid <= 1'b0;
      tick(1);
    end
    tick(4);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    tick(30000);
    err_total++;
    results();
  end

  // ======
  // Sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    adc_sample = 12'h000;
    adc_valid = 1'b0;
    host_data_line = 1'b1;
    power_switch_input_n = 1'b1;
    {cell_hi, cell_lo, chg_oc, dis_oc, short_c, charger} = 6'h00;
    rnd = 16'h0008;
    tick(12);
    presetn <= 1'b1;
    tick(1);
    chk(active_mode, 1'b0);
    rd(BPM_IDX_PROT, 32'h0F);
    rd(BPM_IDX_STATUS, 32'h0);
    rd(BPM_IDX_OFFSET_BIAS, 32'h0);
    rd(10'h3FF, 32'h0);
    chk(rd_err, 1'b1);
    wr(BPM_IDX_PROT, 32'h0);
    power_switch_input_n <= 1'b0;
    tick(5);
    power_switch_input_n <= 1'b1;
    wait_mode(1'b1);
    rd(BPM_IDX_PROT, 32'h06);
    chk(discharge_fet_control, 1'b1);
    wr(BPM_IDX_PROT, 32'h01);
    tick(2);
    chk({charge_fet_control, discharge_fet_control}, 2'b10);
    wr(BPM_IDX_PROT, 32'h03);
    tick(2);
    chk({charge_fet_control, discharge_fet_control}, 2'b00);
    rnd = lfsr(rnd);
    wr(BPM_IDX_ACCUM, {16'h0, rnd});
    rd(BPM_IDX_ACCUM, {16'h0, rnd});
    feed(12'h7FF, 1024);
    rd(BPM_IDX_CURRENT, 32'h7FF);
    rd(BPM_IDX_ACCUM, {16'h0, rnd + 16'h1});
    feed(12'h800, 1024);
    rd(BPM_IDX_CURRENT, 32'h800);
    rd(BPM_IDX_ACCUM, {16'h0, rnd});
    wr(BPM_IDX_CURRENT, 32'h1);
    chk(rd_err, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      smp = (i == 0) ? 12'h7FF : (i == 1) ? 12'h800 : rnd[11:0];
      bias = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : rnd[15:8];
      wr(BPM_IDX_OFFSET_BIAS, {24'h0, bias});
      rd(BPM_IDX_OFFSET_BIAS, {24'h0, bias});
      feed(smp, 128);
      rd(BPM_IDX_CURRENT, exp_cur(smp, bias));
    end
    repeat (3) begin
      cell_hi <= 1'b1;
      tick(DLY - 4);
      cell_hi <= 1'b0;
      tick(2);
    end
    chk(charge_fet_control, 1'b0);
    cell_hi <= 1'b1;
    tick(DLY + 8);
    chk({charge_fet_control, discharge_fet_control}, 2'b10);
    cell_hi <= 1'b0;
    tick(6);
    chk(charge_fet_control, 1'b0);
    rd(BPM_IDX_PROT, 32'h83);
    wr(BPM_IDX_PROT, 32'h03);
    rd(BPM_IDX_PROT, 32'h03);
    dis_oc <= 1'b1;
    tick(DLY + 8);
    chk({discharge_fet_control, charge_fet_control, test_pullup_en}, 3'b101);
    dis_oc <= 1'b0;
    tick(6);
    chk(discharge_fet_control, 1'b0);
    rd(BPM_IDX_PROT, 32'h13);
    wr(BPM_IDX_PROT, 32'h03);
    short_c <= 1'b1;
    tick(SCD + 8);
    chk(discharge_fet_control, 1'b1);
    short_c <= 1'b0;
    tick(6);
    chk(discharge_fet_control, 1'b0);
    rd(BPM_IDX_PROT, 32'h13);
    wr(BPM_IDX_PROT, 32'h03);
    {charger, chg_oc} <= 2'b11;
    tick(DLY + 8);
    chk({charge_fet_control, discharge_fet_control, test_pulldown_en}, 3'b111);
    {charger, chg_oc} <= 2'b00;
    tick(6);
    chk({charge_fet_control, discharge_fet_control}, 2'b00);
    rd(BPM_IDX_PROT, 32'h23);
    wr(BPM_IDX_PROT, 32'h03);
    cell_lo <= 1'b1;
    wait_mode(1'b0);
    cell_lo <= 1'b0;
    chk({charge_fet_control, discharge_fet_control}, 2'b11);
    feed(12'h123, 128);
    charger <= 1'b1;
    wait_mode(1'b1);
    rd(BPM_IDX_CURRENT, exp_cur(smp, bias));
    rd(BPM_IDX_PROT, 32'h43);
    charger <= 1'b0;
    wr(BPM_IDX_PROT, 32'h03);
    wr(BPM_IDX_STATUS, 32'h1);
    host_data_line <= 1'b0;
    tick(DQ - 4);
    chk(active_mode, 1'b1);
    wait_mode(1'b0);
    host_data_line <= 1'b1;
    wait_mode(1'b1);
    wr(BPM_IDX_STATUS, 32'h2);
    wr(BPM_IDX_SWAP, 32'h0);
    wait_mode(1'b0);
    charger <= 1'b1;
    tick(10);
    chk(active_mode, 1'b0);
    charger <= 1'b0;
    wr(BPM_IDX_SWAP, 32'h1);
    wait_mode(1'b1);
    rd(BPM_IDX_STATUS, 32'h82);
    results();
  end
endmodule

// ===== core/bpm_mode_ctrl.sv
// Power mode state machine, cell protection, current measurement and APB registers
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module bpm_mode_ctrl
  import bpm_pkg::*;
#(
  parameter int DQ_LOW_CYC = BPM_DQ_LOW_CYC,
  parameter int OVD_CYC = BPM_OVD_CYC,
  parameter int UVD_CYC = BPM_UVD_CYC,
  parameter int OCD_CYC = BPM_OCD_CYC,
  parameter int SCD_CYC = BPM_SCD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_data_line,
  input wire logic power_switch_input_n,
  input wire logic cmp_vin_gt_ov,
  input wire logic cmp_vin_lt_uv,
  input wire logic cmp_vin_lt_ce,
  input wire logic cmp_is_gt_oc,
  input wire logic cmp_is_lt_neg_oc,
  input wire logic cmp_is_le_neg_2mv,
  input wire logic cmp_sns_gt_sc,
  input wire logic cmp_pls_gt_vin,
  input wire logic cmp_pls_gt_vdd,
  input wire logic cmp_vdd_gt_2v2,
  input wire logic cmp_pls_lt_vdd_tp,
  input wire logic cmp_pls_gt_vdd_tp,
  input wire logic [11:0] adc_sample,
  input wire logic adc_valid,
  output logic charge_fet_control,
  output logic discharge_fet_control,
  output logic active_mode,
  output logic test_pulldown_en,
  output logic test_pullup_en
);

  // ==========================================================================
  // Pin synchronisers
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;

  assign pin_raw = {host_data_line, power_switch_input_n, cmp_vin_gt_ov, cmp_vin_lt_uv,
                    cmp_vin_lt_ce, cmp_is_gt_oc, cmp_is_lt_neg_oc, cmp_is_le_neg_2mv,
                    cmp_sns_gt_sc, cmp_pls_gt_vin, cmp_pls_gt_vdd, cmp_vdd_gt_2v2,
                    cmp_pls_lt_vdd_tp, cmp_pls_gt_vdd_tp};

  // Idle-high reset values keep a floating host line and switch from acting at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= {2'b11, 12'h000};
      sync2_ff <= {2'b11, 12'h000};
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic dq_s, ps_n_s, ov_s, uv_s, vce_s, occ_s, ocd_s, m2mv_s, sc_s;
  logic plsvin_s, plsvdd_s, vdd22_s, plslo_s, plshi_s;
  assign {dq_s, ps_n_s, ov_s, uv_s, vce_s, occ_s, ocd_s, m2mv_s, sc_s, plsvin_s,
          plsvdd_s, vdd22_s, plslo_s, plshi_s} = sync2_ff;

  // ==========================================================================
  // Registers and state
  bpm_mode_t mode_ff;
  bpm_mode_t nxt_mode;
  logic ov_flag_ff, uv_flag_ff, coc_flag_ff, doc_flag_ff;
  logic ov_cond_ff, uv_cond_ff, coc_cond_ff, doc_cond_ff;
  logic ce_ff, de_ff, pack_disconnect_sleep_enable_ff, swap_enable_ff;
  logic [7:0] bias_ff;
  logic [15:0] accum_ff;
  logic signed [11:0] current_ff;
  logic cc_off_ff, dc_off_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic running;

  assign running = (mode_ff == BPM_ACTIVE);

  // ==========================================================================
  // Qualifying timers: dq low, ov, uv, charge oc, discharge oc, short
  localparam int NQ = 6;
  localparam int DLY [NQ] = '{DQ_LOW_CYC, OVD_CYC, UVD_CYC, OCD_CYC, OCD_CYC, SCD_CYC};
  logic [NQ-1:0] q_cond;
  logic [NQ-1:0] q_hit;

  assign q_cond = {sc_s, ocd_s, occ_s, uv_s, ov_s, pack_disconnect_sleep_enable_ff && !dq_s};

  genvar gi;
  generate
    for (gi = 0; gi < NQ; gi = gi + 1) begin : g_qual
      bpm_qual_timer #(.CYCLES(DLY[gi])) u_timer (
        .clk(pclk),
        .rst_n(presetn),
        .run(running),
        .cond(q_cond[gi]),
        .qualified(q_hit[gi])
      );
    end
  endgenerate

  logic dq_lost, ov_hit, uv_hit, occ_hit, ocd_hit, sc_hit;
  assign {sc_hit, ocd_hit, occ_hit, uv_hit, ov_hit, dq_lost} = q_hit;

  // ==========================================================================
  // APB decode
  logic [9:0] idx;
  logic setup, wr_en, rd_en, mapped;
  assign idx = paddr[11:2];
  assign setup = psel && !penable && !pready_ff;
  assign wr_en = psel && penable && pready_ff && pwrite && mapped;
  assign rd_en = setup && !pwrite;

  always_comb begin
    if (idx == BPM_IDX_PROT) begin
      mapped = 1'b1;
    end else if (idx == BPM_IDX_STATUS) begin
      mapped = 1'b1;
    end else if (idx == BPM_IDX_SWAP) begin
      mapped = 1'b1;
    end else if (idx == BPM_IDX_CURRENT) begin
      mapped = !pwrite;
    end else if (idx == BPM_IDX_ACCUM) begin
      mapped = 1'b1;
    end else if (idx == BPM_IDX_OFFSET_BIAS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  logic wr_prot, wr_stat, wr_swap, wr_acc, wr_bias;
  assign wr_prot = wr_en && (idx == BPM_IDX_PROT);
  assign wr_stat = wr_en && (idx == BPM_IDX_STATUS);
  assign wr_swap = wr_en && (idx == BPM_IDX_SWAP);
  assign wr_acc = wr_en && (idx == BPM_IDX_ACCUM);
  assign wr_bias = wr_en && (idx == BPM_IDX_OFFSET_BIAS);

  // No wait states: pready rises in the first access cycle and lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (rd_en) begin
      if (idx == BPM_IDX_PROT) begin
        prdata_ff <= {24'h000000, ov_flag_ff, uv_flag_ff, coc_flag_ff, doc_flag_ff,
                      cc_off_ff, dc_off_ff, ce_ff, de_ff};
      end else if (idx == BPM_IDX_STATUS) begin
        prdata_ff <= {24'h000000, running, 5'h00, swap_enable_ff, pack_disconnect_sleep_enable_ff};
      end else if (idx == BPM_IDX_CURRENT) begin
        prdata_ff <= {20'h00000, current_ff};
      end else if (idx == BPM_IDX_ACCUM) begin
        prdata_ff <= {16'h0000, accum_ff};
      end else if (idx == BPM_IDX_OFFSET_BIAS) begin
        prdata_ff <= {24'h000000, bias_ff};
      end else begin
        prdata_ff <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pack_disconnect_sleep_enable_ff <= 1'b0;
      swap_enable_ff <= 1'b0;
      bias_ff <= BPM_RST_OFFSET_BIAS;
    end else begin
      if (wr_stat) begin
        pack_disconnect_sleep_enable_ff <= pwdata[BPM_STAT_PACK_DISCONNECT_SLEEP_ENABLE];
        swap_enable_ff <= pwdata[BPM_STAT_SWAP_ENABLE];
      end
      if (wr_bias) begin
        bias_ff <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Power mode state machine
  logic swap_off, swap_on, wake;
  assign swap_off = wr_swap && swap_enable_ff && !pwdata[0];
  assign swap_on = wr_swap && swap_enable_ff && pwdata[0];
  assign wake = (pack_disconnect_sleep_enable_ff && !swap_enable_ff && dq_s)
             || !ps_n_s
             || (plsvin_s && !swap_enable_ff)
             || swap_on;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      BPM_ACTIVE: begin
        if (dq_lost || uv_hit || swap_off) begin
          nxt_mode = BPM_SLEEP;
        end
      end
      BPM_SLEEP: begin
        if (wake) begin
          nxt_mode = BPM_ACTIVE;
        end
      end
      default: nxt_mode = BPM_SLEEP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= BPM_SLEEP;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Permit bits; the wake-up force on ce outranks a host write in the same cycle; de follows host writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_ff <= BPM_RST_CE;
      de_ff <= BPM_RST_DE;
    end else begin
      if (mode_ff == BPM_SLEEP && nxt_mode == BPM_ACTIVE) begin
        ce_ff <= 1'b1;
      end else if (wr_prot) begin
        ce_ff <= pwdata[BPM_PROT_CE];
      end
      if (wr_prot) begin
        de_ff <= pwdata[BPM_PROT_DE];
      end
    end
  end

  // ==========================================================================
  // Live protection conditions with their release tests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_cond_ff <= 1'b0;
      uv_cond_ff <= 1'b0;
      coc_cond_ff <= 1'b0;
      doc_cond_ff <= 1'b0;
    end else begin
      if (ov_hit) begin
        ov_cond_ff <= 1'b1;
      end else if (vce_s || m2mv_s) begin
        ov_cond_ff <= 1'b0;
      end
      if (uv_hit) begin
        uv_cond_ff <= 1'b1;
      end else if (plsvdd_s && vdd22_s) begin
        uv_cond_ff <= 1'b0;
      end
      if (occ_hit) begin
        coc_cond_ff <= 1'b1;
      end else if (coc_cond_ff && plslo_s) begin
        coc_cond_ff <= 1'b0;
      end
      if (ocd_hit || sc_hit) begin
        doc_cond_ff <= 1'b1;
      end else if (doc_cond_ff && plshi_s) begin
        doc_cond_ff <= 1'b0;
      end
    end
  end

  // Sticky flags: a new event wins over a host clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_flag_ff <= 1'b0;
      uv_flag_ff <= 1'b0;
      coc_flag_ff <= 1'b0;
      doc_flag_ff <= 1'b0;
    end else begin
      ov_flag_ff <= ov_hit || (ov_flag_ff && !(wr_prot && !pwdata[BPM_PROT_OV]));
      uv_flag_ff <= uv_hit || (uv_flag_ff && !(wr_prot && !pwdata[BPM_PROT_UV]));
      coc_flag_ff <= occ_hit || (coc_flag_ff && !(wr_prot && !pwdata[BPM_PROT_COC]));
      doc_flag_ff <= ocd_hit || sc_hit
                  || (doc_flag_ff && !(wr_prot && !pwdata[BPM_PROT_DOC]));
    end
  end

  // ==========================================================================
  // FET controls (high = FET off) and release test currents
  logic nxt_cc_off, nxt_dc_off;
  assign nxt_cc_off = ov_cond_ff || ov_hit || uv_cond_ff || uv_hit || coc_cond_ff
                   || occ_hit || !ce_ff || (nxt_mode == BPM_SLEEP);
  assign nxt_dc_off = uv_cond_ff || uv_hit || coc_cond_ff || occ_hit || doc_cond_ff
                   || ocd_hit || sc_hit || !de_ff || (nxt_mode == BPM_SLEEP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_off_ff <= 1'b1;
      dc_off_ff <= 1'b1;
    end else begin
      cc_off_ff <= nxt_cc_off;
      dc_off_ff <= nxt_dc_off;
    end
  end

  // ==========================================================================
  // Current averaging with offset bias, saturation and accumulation
  logic [6:0] samp_cnt_ff;
  logic signed [19:0] sum_ff;
  logic signed [12:0] corrected;
  logic signed [19:0] sum_next;
  logic signed [12:0] avg;
  logic signed [11:0] avg_sat;
  logic avg_done;

  assign corrected = 13'(signed'(adc_sample)) - 13'(signed'(bias_ff));
  assign sum_next = sum_ff + 20'(corrected);
  assign avg = 13'(sum_next >>> BPM_AVG_SHIFT);
  assign avg_done = running && adc_valid && (samp_cnt_ff == 7'(BPM_AVG_SAMPLES - 1));

  always_comb begin
    if (avg > 13'(BPM_CUR_MAX)) begin
      avg_sat = BPM_CUR_MAX;
    end else if (avg < 13'(BPM_CUR_MIN)) begin
      avg_sat = BPM_CUR_MIN;
    end else begin
      avg_sat = avg[11:0];
    end
  end

  // Sampling stops in sleep; the partial average is discarded there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt_ff <= 7'h00;
      sum_ff <= 20'sh00000;
      current_ff <= 12'sh000;
    end else if (!running) begin
      samp_cnt_ff <= 7'h00;
      sum_ff <= 20'sh00000;
    end else if (adc_valid) begin
      samp_cnt_ff <= samp_cnt_ff + 7'h01;
      if (avg_done) begin
        sum_ff <= 20'sh00000;
        current_ff <= avg_sat;
      end else begin
        sum_ff <= sum_next;
      end
    end
  end

  // Residue carries fractions of an accumulator count between updates
  logic signed [15:0] resid_ff;
  logic signed [15:0] resid_sum;
  assign resid_sum = resid_ff + 16'(avg_sat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_ff <= BPM_RST_ACCUM;
      resid_ff <= 16'sh0000;
    end else if (wr_acc) begin
      accum_ff <= pwdata[15:0];
    end else if (avg_done) begin
      if (resid_sum >= 16'(BPM_ACC_DIV)) begin
        accum_ff <= accum_ff + 16'h0001;
        resid_ff <= resid_sum - 16'(BPM_ACC_DIV);
      end else if (resid_sum <= -16'(BPM_ACC_DIV)) begin
        accum_ff <= accum_ff - 16'h0001;
        resid_ff <= resid_sum + 16'(BPM_ACC_DIV);
      end else begin
        resid_ff <= resid_sum;
      end
    end
  end

  // ==========================================================================
  // Outputs
  logic pd_ff, pu_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_ff <= 1'b0;
      pu_ff <= 1'b0;
    end else begin
      pd_ff <= coc_cond_ff || occ_hit;
      pu_ff <= doc_cond_ff || ocd_hit || sc_hit;
    end
  end

  assign charge_fet_control = cc_off_ff;
  assign discharge_fet_control = dc_off_ff;
  assign active_mode = mode_ff;
  assign test_pulldown_en = pd_ff;
  assign test_pullup_en = pu_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

// ===== core/bpm_pkg.sv
// Shared constants for the battery protection mode controller
package bpm_pkg;

  // ==========================================================================
  // Time base
  localparam int BPM_CLK_KHZ = 25000;

  // Qualifying delays: times in their own units, cycle counts derived
  localparam int BPM_DQ_LOW_MS = 2000;
  localparam int BPM_OVD_MS = 1000;
  localparam int BPM_UVD_MS = 100;
  localparam int BPM_OCD_MS = 10;
  localparam int BPM_SCD_US = 200;
  localparam int BPM_DQ_LOW_CYC = BPM_DQ_LOW_MS * BPM_CLK_KHZ;
  localparam int BPM_OVD_CYC = BPM_OVD_MS * BPM_CLK_KHZ;
  localparam int BPM_UVD_CYC = BPM_UVD_MS * BPM_CLK_KHZ;
  localparam int BPM_OCD_CYC = BPM_OCD_MS * BPM_CLK_KHZ;
  localparam int BPM_SCD_CYC = (BPM_SCD_US * BPM_CLK_KHZ + 999) / 1000;

  // ==========================================================================
  // Measurement
  localparam int BPM_AVG_SAMPLES = 128;
  localparam int BPM_AVG_SHIFT = 7;
  localparam logic signed [11:0] BPM_CUR_MAX = 12'sh7FF;
  localparam logic signed [11:0] BPM_CUR_MIN = -12'sh800;
  // Averaged current counts (0.625 mA x 88 ms) per 0.25 mAh accumulator count
  localparam int BPM_ACC_DIV = 16364;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [9:0] BPM_IDX_PROT = 10'h000;
  localparam logic [9:0] BPM_IDX_STATUS = 10'h001;
  localparam logic [9:0] BPM_IDX_SWAP = 10'h002;
  localparam logic [9:0] BPM_IDX_CURRENT = 10'h00E;
  localparam logic [9:0] BPM_IDX_ACCUM = 10'h010;
  localparam logic [9:0] BPM_IDX_OFFSET_BIAS = 10'h033;

  // Protection register fields
  localparam int BPM_PROT_OV = 7;
  localparam int BPM_PROT_UV = 6;
  localparam int BPM_PROT_COC = 5;
  localparam int BPM_PROT_DOC = 4;
  localparam int BPM_PROT_CC = 3;
  localparam int BPM_PROT_DC = 2;
  localparam int BPM_PROT_CE = 1;
  localparam int BPM_PROT_DE = 0;
  // Status register fields
  localparam int BPM_STAT_ACTIVE = 7;
  localparam int BPM_STAT_SWAP_ENABLE = 1;
  localparam int BPM_STAT_PACK_DISCONNECT_SLEEP_ENABLE = 0;

  // Reset values
  localparam logic BPM_RST_CE = 1'b1;
  localparam logic BPM_RST_DE = 1'b1;
  localparam logic [7:0] BPM_RST_OFFSET_BIAS = 8'h00;
  localparam logic [15:0] BPM_RST_ACCUM = 16'h0000;

  typedef enum logic {
    BPM_SLEEP = 1'b0,
    BPM_ACTIVE = 1'b1
  } bpm_mode_t;

endpackage

// ===== core/bpm_qual_timer.sv
// Qualifying delay timer: condition must hold continuously for the full delay
`timescale 1ns/1ns
module bpm_qual_timer #(
  parameter int CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic cond,
  output logic qualified
);

  logic [31:0] cnt_ff;
  logic hit;

  assign hit = (cnt_ff == 32'(CYCLES));

  // Any break in the condition restarts the delay from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h00000000;
    end else if (!(run && cond)) begin
      cnt_ff <= 32'h00000000;
    end else if (!hit) begin
      cnt_ff <= cnt_ff + 32'h00000001;
    end
  end

  assign qualified = hit && run && cond;

endmodule
